// ---- baud_pkg.sv ----
`default_nettype none
package baud_pkg;
    localparam logic [7:0] ADDR_DIVISOR_LOW = 8'h00;
    localparam logic [7:0] ADDR_DIVISOR_HIGH = 8'h04;
    localparam logic [7:0] ADDR_BAUD_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_TX_CONTROL = 8'h0C;

    // Baud rate control fields.
    localparam int BIT_AUTOBAUD_ENABLE = 0;
    localparam int BIT_WIDE_DIVIDER = 3;
    localparam int BIT_RECEIVE_IDLE = 6;
    // Transmit status and control fields.
    localparam int BIT_HIGH_SPEED = 2;
    localparam int BIT_SYNC_MODE = 4;

    localparam logic [7:0] DIVISOR_RESET = 8'h00;
    localparam logic BIT_RESET = 1'b0;

    // Prescale limits: the divide ratio minus one.
    localparam logic [5:0] PRESCALE_64 = 6'h3F;
    localparam logic [5:0] PRESCALE_16 = 6'h0F;
    localparam logic [5:0] PRESCALE_4 = 6'h03;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    function automatic logic [5:0] prescale_select(input logic sync, input logic wide, input logic high_speed);
        logic [5:0] sel;
        sel = PRESCALE_4;
        if (!sync) begin
            if (!wide) begin
                sel = high_speed ? PRESCALE_16 : PRESCALE_64;
            end else begin
                sel = high_speed ? PRESCALE_4 : PRESCALE_16;
            end
        end
        return sel;
    endfunction : prescale_select
endpackage : baud_pkg
`default_nettype wire

// ---- baud_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface baud_if;
    logic [15:0] divisor;
    logic wide;
    logic [5:0] prescale_max;
    logic restart;
    logic tick;
    modport ctrl (output divisor, output wide, output prescale_max, output restart, input tick);
    modport timer (input divisor, input wide, input prescale_max, input restart, output tick);
endinterface : baud_if
`default_nettype wire

// ---- baud_divider.sv ----
`timescale 1ns/10ps
`default_nettype none
module baud_divider
    import baud_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic reset,
    // Control from the register block.
    baud_if.timer bus
);
    logic [5:0] pre_r;
    logic [15:0] count_r;
    logic tick_r;
    logic [15:0] limit;
    logic pre_end;
    logic cnt_end;

    // In narrow mode only the low divisor byte sets the period.
    assign limit = bus.wide ? bus.divisor : {8'h00, bus.divisor[7:0]};
    assign pre_end = (pre_r == bus.prescale_max);
    assign cnt_end = (count_r >= limit);
    assign bus.tick = tick_r;

    always_ff @(posedge mclk) begin
        if (reset || bus.restart) begin
            pre_r <= '0;
            count_r <= '0;
            tick_r <= 1'b0;
        end else begin
            pre_r <= pre_end ? 6'h00 : pre_r + 6'h01;
            if (pre_end) begin
                count_r <= cnt_end ? 16'h0000 : count_r + 16'h0001;
            end
            tick_r <= pre_end && cnt_end;
        end
    end

    // Helper logic: cycles since the last tick, and whether the setup moved since.
    logic [22:0] gap_r;
    logic moved_r;
    logic [22:0] expect_gap;
    assign expect_gap = 23'((({17'h00000, bus.prescale_max} + 23'h1) * ({7'h00, limit} + 23'h1)) - 23'h1);
    always_ff @(posedge mclk) begin
        if (reset || bus.restart) begin
            gap_r <= '0;
            moved_r <= 1'b1;
        end else begin
            gap_r <= bus.tick ? 23'h000001 : gap_r + 23'h000001;
            if (bus.tick) begin
                moved_r <= 1'b0;
            end else if ($changed(bus.prescale_max) || $changed(limit)) begin
                moved_r <= 1'b1;
            end
        end
    end

    a_period_exact: assert property (@(posedge mclk) disable iff (reset)
        tick_r && !moved_r && !bus.restart |-> gap_r == expect_gap + 23'h1)
        else $error("baud tick spacing differs from prescale times divisor plus one");
    a_restart_clears: assert property (@(posedge mclk) disable iff (reset)
        bus.restart |=> pre_r == 6'h00 && count_r == 16'h0000 && !tick_r)
        else $error("divisor write did not clear the baud timer");
    a_narrow_width: assert property (@(posedge mclk) disable iff (reset)
        !bus.wide && !moved_r && $stable(limit) && !$past(bus.restart) |-> count_r[15:8] == 8'h00)
        else $error("narrow divider counted past eight bits");
    a_sixteen_wide: assert property (@(posedge mclk) disable iff (reset)
        bus.wide && bus.divisor == 16'hFFFF && count_r == 16'h00FF && pre_end && !bus.restart |=> count_r == 16'h0100)
        else $error("wide divider did not count past eight bits");
endmodule : baud_divider
`default_nettype wire

// ---- baud_rate_generator.sv ----
// Function
// - Dedicated divider runs as 8-bit or 16-bit counter for both modes.
// - Reset gives 8-bit counting; wide divider select gives 16-bit.
// - Divisor high and low together set the free running timer period in 16-bit mode; 8-bit mode uses the low byte only.
// - Async multiplier follows high speed select and wide divider select.
// - Sync mode ignores high speed select; wide select still applies.
// - Writing either divisor register clears the baud timer immediately.
// - Async, 8-bit, normal speed: clock divided by 64 times (n+1).
// - Async, 16-bit, normal speed: clock divided by 16 times (n+1).
// - Sync mode: clock divided by 4 times (n+1) in both widths.
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module baud_rate_generator
    import baud_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic reset,
    // AXI4-Lite write address and data.
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read.
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Receiver and auto-baud engine.
    input wire logic receive_idle,
    input wire logic autobaud_done,
    output logic autobaud_active,
    // Baud clock enable and mode to the serial engines.
    output logic baud_tick,
    output logic sync_mode
);
    baud_if bus ();

    logic [7:0] divisor_low_r;
    logic [7:0] divisor_high_r;
    logic wide_r;
    logic high_speed_r;
    logic sync_r;
    logic autobaud_r;
    logic autobaud_nxt;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;

    function automatic logic is_mapped(input logic [7:0] addr);
        return addr == ADDR_DIVISOR_LOW || addr == ADDR_DIVISOR_HIGH ||
            addr == ADDR_BAUD_CONTROL || addr == ADDR_TX_CONTROL;
    endfunction : is_mapped

    // Write path: address and data are taken together in one beat.
    logic wr_go;
    logic [7:0] wr_addr;
    logic wr_lane0;
    logic we_low;
    logic we_high;
    logic we_baud;
    logic we_tx;
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
    assign wr_addr = 8'(s_axi_awaddr);
    assign wr_lane0 = wr_go && s_axi_wstrb[0];
    assign we_low = wr_lane0 && wr_addr == ADDR_DIVISOR_LOW;
    assign we_high = wr_lane0 && wr_addr == ADDR_DIVISOR_HIGH;
    assign we_baud = wr_lane0 && wr_addr == ADDR_BAUD_CONTROL;
    assign we_tx = wr_lane0 && wr_addr == ADDR_TX_CONTROL;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    // A software write wins over the completion clear.
    assign autobaud_nxt = we_baud ? s_axi_wdata[BIT_AUTOBAUD_ENABLE] : (autobaud_done ? 1'b0 : autobaud_r);

    always_ff @(posedge mclk) begin
        if (reset) begin
            divisor_low_r <= DIVISOR_RESET;
            divisor_high_r <= DIVISOR_RESET;
            wide_r <= BIT_RESET;
            high_speed_r <= BIT_RESET;
            sync_r <= BIT_RESET;
            autobaud_r <= BIT_RESET;
        end else begin
            if (we_low) begin
                divisor_low_r <= s_axi_wdata[7:0];
            end
            if (we_high) begin
                divisor_high_r <= s_axi_wdata[7:0];
            end
            if (we_baud) begin
                wide_r <= s_axi_wdata[BIT_WIDE_DIVIDER];
            end
            if (we_tx) begin
                high_speed_r <= s_axi_wdata[BIT_HIGH_SPEED];
                sync_r <= s_axi_wdata[BIT_SYNC_MODE];
            end
            autobaud_r <= autobaud_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= is_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // Read path.
    logic rd_go;
    logic [7:0] rd_addr;
    logic [31:0] rd_word;
    assign rd_go = s_axi_arvalid && !rvalid_r;
    assign rd_addr = 8'(s_axi_araddr);
    assign rd_word = rd_addr == ADDR_DIVISOR_LOW ? {24'h000000, divisor_low_r} :
        rd_addr == ADDR_DIVISOR_HIGH ? {24'h000000, divisor_high_r} :
        rd_addr == ADDR_BAUD_CONTROL ? 32'((32'(receive_idle) << BIT_RECEIVE_IDLE) |
            (32'(wide_r) << BIT_WIDE_DIVIDER) | (32'(autobaud_r) << BIT_AUTOBAUD_ENABLE)) :
        rd_addr == ADDR_TX_CONTROL ? 32'((32'(sync_r) << BIT_SYNC_MODE) | (32'(high_speed_r) << BIT_HIGH_SPEED)) :
        32'h00000000;
    assign s_axi_arready = rd_go;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    always_ff @(posedge mclk) begin
        if (reset) begin
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= 32'h00000000;
        end else if (rd_go) begin
            rvalid_r <= 1'b1;
            rresp_r <= is_mapped(rd_addr) ? RESP_OKAY : RESP_SLVERR;
            rdata_r <= rd_word;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    assign bus.divisor = {divisor_high_r, divisor_low_r};
    assign bus.wide = wide_r;
    assign bus.prescale_max = prescale_select(sync_r, wide_r, high_speed_r);
    assign bus.restart = we_low || we_high;

    baud_divider u_divider (
        .mclk(mclk),
        .reset(reset),
        .bus(bus)
    );

    assign baud_tick = bus.tick;
    assign sync_mode = sync_r;
    // Detection runs only in async mode.
    assign autobaud_active = autobaud_r && !sync_r;

    a_reset_narrow: assert property (@(posedge mclk)
        reset |=> !wide_r && !high_speed_r && !sync_r && bus.prescale_max == PRESCALE_64)
        else $error("divider not narrow async after reset");
    a_write_restart: assert property (@(posedge mclk) disable iff (reset)
        wr_go && s_axi_wstrb[0] && (wr_addr == ADDR_DIVISOR_LOW || wr_addr == ADDR_DIVISOR_HIGH) |-> bus.restart)
        else $error("divisor write did not restart the timer");
    a_async_slow8: assert property (@(posedge mclk) disable iff (reset)
        !sync_r && !wide_r && !high_speed_r |-> bus.prescale_max == PRESCALE_64)
        else $error("async narrow normal speed not divide by 64");
    a_async_slow16: assert property (@(posedge mclk) disable iff (reset)
        !sync_r && wide_r && !high_speed_r |-> bus.prescale_max == PRESCALE_16)
        else $error("async wide normal speed not divide by 16");
    a_sync_ratio: assert property (@(posedge mclk) disable iff (reset)
        sync_r |-> bus.prescale_max == PRESCALE_4)
        else $error("sync mode not divide by 4");
    a_sync_ignores_speed: assert property (@(posedge mclk) disable iff (reset)
        sync_r && $stable(sync_r) && $changed(high_speed_r) |-> $stable(bus.prescale_max))
        else $error("high speed select changed sync divide");
    a_async_fast: assert property (@(posedge mclk) disable iff (reset)
        !sync_r && high_speed_r |-> bus.prescale_max == (wide_r ? PRESCALE_4 : PRESCALE_16))
        else $error("async high speed ratio wrong");
    a_async_mode_pick: assert property (@(posedge mclk) disable iff (reset)
        !sync_r && $changed(high_speed_r) && $stable(wide_r) && $stable(sync_r) |-> $changed(bus.prescale_max))
        else $error("high speed select did not change async multiplier");
    a_autobaud_clear: assert property (@(posedge mclk) disable iff (reset)
        autobaud_done && !we_baud |=> !autobaud_r && !autobaud_active)
        else $error("auto-baud bit not cleared on completion");
    a_autobaud_sync: assert property (@(posedge mclk) disable iff (reset)
        sync_r |-> !autobaud_active)
        else $error("auto-baud active in sync mode");
    a_write_answer: assert property (@(posedge mclk) disable iff (reset)
        wr_go |=> s_axi_bvalid && !s_axi_awready)
        else $error("write response missing");
    a_read_answer: assert property (@(posedge mclk) disable iff (reset)
        rd_go |=> s_axi_rvalid && !s_axi_arready)
        else $error("read response missing");
endmodule : baud_rate_generator
`default_nettype wire

// ---- serial_baud_rate_generator_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module serial_baud_rate_generator_bench;
    import baud_pkg::*;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic receive_idle = 1'b1, autobaud_done = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, autobaud_active, baud_tick, sync_mode;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, rd;
    logic [1:0] rs;
    int bad_count = 0;
    int tests_run = 0;
    int gap;
    int ticks;

    always #12.5 mclk = ~mclk;

    baud_rate_generator i_dut (.mclk(mclk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .receive_idle(receive_idle),
        .autobaud_done(autobaud_done), .autobaud_active(autobaud_active), .baud_tick(baud_tick),
        .sync_mode(sync_mode));

    task complete_run;
        $display("counts: %0d compared, %0d mismatched", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    task check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task timed_out;
        bad_count++;
        $display("ERROR at %0t: got %h expected %h", $time, 32'h0, 32'h1);
        complete_run();
    endtask : timed_out

    // Address and data go out together; each is dropped once its own ready is seen.
    task axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        int i;
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge mclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        if (i == 50) timed_out();
        bready <= 1'b0;
        check(bresp, er);
    endtask : axi_write

    task axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int i;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge mclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        if (i == 50) timed_out();
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axi_read

    task read_check(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        axi_read(a, rd, rs);
        check(rd, ed);
        check(rs, er);
    endtask : read_check

    task set_mode(input logic sy, input logic wi, input logic hs, input logic [7:0] hi, input logic [7:0] lo);
        axi_write(ADDR_TX_CONTROL, {27'h0, sy, 1'b0, hs, 2'h0}, 4'hF, RESP_OKAY);
        axi_write(ADDR_BAUD_CONTROL, {28'h0, wi, 3'h0}, 4'hF, RESP_OKAY);
        axi_write(ADDR_DIVISOR_HIGH, {24'h0, hi}, 4'hF, RESP_OKAY);
        axi_write(ADDR_DIVISOR_LOW, {24'h0, lo}, 4'hF, RESP_OKAY);
    endtask : set_mode

    // Counts edges up to the next baud tick.
    task wait_tick(output int n);
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (baud_tick !== 1'b1 && n < 20000);
        if (n >= 20000) timed_out();
    endtask : wait_tick

    function automatic int ratio(input logic sy, input logic wi, input logic hs);
        if (sy) return 4;
        if (!wi) return hs ? 16 : 64;
        return hs ? 4 : 16;
    endfunction : ratio

    initial begin
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        // Reset state of every register, with the receiver reported idle.
        read_check(ADDR_DIVISOR_LOW, 32'h0, RESP_OKAY);
        read_check(ADDR_DIVISOR_HIGH, 32'h0, RESP_OKAY);
        read_check(ADDR_BAUD_CONTROL, 32'h40, RESP_OKAY);
        read_check(ADDR_TX_CONTROL, 32'h0, RESP_OKAY);
        check(sync_mode, 1'b0);
        $display("test reset_values done");
        // Period for every mode; the high byte counts only in 16-bit mode.
        for (int m = 0; m < 8; m++) begin
            set_mode(m[2], m[1], m[0], 8'h01, 8'h02);
            check(sync_mode, m[2]);
            wait_tick(gap);
            wait_tick(gap);
            check(gap, ratio(m[2], m[1], m[0]) * (m[1] ? 259 : 3));
        end
        // A full 16-bit divisor must carry past eight bits without a tick.
        set_mode(1'b1, 1'b1, 1'b0, 8'hFF, 8'hFF);
        ticks = 0;
        repeat (1100) begin
            @(posedge mclk);
            if (baud_tick === 1'b1) ticks++;
        end
        check(ticks, 0);
        $display("test tick_periods done");
        // Rewriting either divisor byte mid-count restarts the full period.
        set_mode(1'b0, 1'b0, 1'b0, 8'h00, 8'h02);
        wait_tick(gap);
        repeat (100) @(posedge mclk);
        axi_write(ADDR_DIVISOR_LOW, 32'h02, 4'hF, RESP_OKAY);
        wait_tick(gap);
        check(gap, ratio(1'b0, 1'b0, 1'b0) * 3);
        repeat (100) @(posedge mclk);
        axi_write(ADDR_DIVISOR_HIGH, 32'h00, 4'hF, RESP_OKAY);
        wait_tick(gap);
        check(gap, ratio(1'b0, 1'b0, 1'b0) * 3);
        $display("test divisor_restart done");
        // Auto-baud enable, self-clear and sync-mode inertness.
        axi_write(ADDR_BAUD_CONTROL, 32'h01, 4'hF, RESP_OKAY);
        check(autobaud_active, 1'b1);
        autobaud_done <= 1'b1;
        @(posedge mclk);
        autobaud_done <= 1'b0;
        @(posedge mclk);
        check(autobaud_active, 1'b0);
        read_check(ADDR_BAUD_CONTROL, 32'h40, RESP_OKAY);
        axi_write(ADDR_TX_CONTROL, 32'h10, 4'hF, RESP_OKAY);
        axi_write(ADDR_BAUD_CONTROL, 32'h01, 4'hF, RESP_OKAY);
        check(autobaud_active, 1'b0);
        receive_idle <= 1'b0;
        read_check(ADDR_BAUD_CONTROL, 32'h01, RESP_OKAY);
        $display("test autobaud done");
        // Disabled byte lane leaves the registers alone; unmapped address answers SLVERR on write and read.
        axi_write(ADDR_BAUD_CONTROL, 32'h08, 4'h0, RESP_OKAY);
        read_check(ADDR_BAUD_CONTROL, 32'h01, RESP_OKAY);
        axi_write(8'h10, 32'hFF, 4'hF, RESP_SLVERR);
        read_check(8'h10, 32'h0, RESP_SLVERR);
        $display("test bus_errors done");
        complete_run();
    end
endmodule : serial_baud_rate_generator_bench
`default_nettype wire
